// File: shared/am_seg_pkg.sv
package am_seg_pkg;

    // ==========================================================
    // Widths
    localparam int ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam int REG_W = 8;
    localparam int TARGET_W = 6;

    // ==========================================================
    // Register indices and byte addresses (index times four)
    localparam logic [ADDR_W-1:0] IDX_DEPTH_CONTROL = 8'h24;
    localparam logic [ADDR_W-1:0] IDX_DEPTH_RESULT = 8'h25;
    localparam logic [ADDR_W-1:0] IDX_MODULATED_MASK = 8'h26;
    localparam logic [ADDR_W-1:0] IDX_NORMAL_MASK = 8'h27;
    localparam logic [ADDR_W-1:0] ADDR_DEPTH_CONTROL = 8'h90;
    localparam logic [ADDR_W-1:0] ADDR_DEPTH_RESULT = 8'h94;
    localparam logic [ADDR_W-1:0] ADDR_MODULATED_MASK = 8'h98;
    localparam logic [ADDR_W-1:0] ADDR_NORMAL_MASK = 8'h9C;

    // ==========================================================
    // Field positions and values
    localparam int SOURCE_SELECT_BIT = 7;
    localparam int TARGET_LEVEL_MSB = 6;
    localparam int TARGET_LEVEL_LSB = 1;
    localparam logic [REG_W-1:0] REG_RESET = 8'h00;
    localparam logic [REG_W-1:0] CAL_FAIL_VALUE = 8'hFF;
    localparam logic [REG_W-1:0] TRISTATE_MASK = 8'hFF;
    localparam logic [TARGET_W-1:0] TARGET_RESET = 6'h00;
    localparam logic SOURCE_CALIBRATED = 1'b0;
    localparam logic SOURCE_MANUAL = 1'b1;

    // ==========================================================
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_DEPTH_CONTROL = 3'h1,
        SEL_DEPTH_RESULT = 3'h3,
        SEL_MODULATED_MASK = 3'h2,
        SEL_NORMAL_MASK = 3'h6
    } reg_sel_e;

    // Word-aligned decode; low two address bits are ignored
    function automatic reg_sel_e reg_decode(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] word;
        word = {addr[ADDR_W-1:2], 2'h0};
        case (word)
            ADDR_DEPTH_CONTROL: reg_decode = SEL_DEPTH_CONTROL;
            ADDR_DEPTH_RESULT: reg_decode = SEL_DEPTH_RESULT;
            ADDR_MODULATED_MASK: reg_decode = SEL_MODULATED_MASK;
            ADDR_NORMAL_MASK: reg_decode = SEL_NORMAL_MASK;
            default: reg_decode = SEL_NONE;
        endcase
    endfunction

endpackage

// File: hdl/axil_reg_port.sv
`timescale 1ns/10ps
module axil_reg_port (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // AXI4-Lite write
    input wire logic [am_seg_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [am_seg_pkg::AXI_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [am_seg_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [am_seg_pkg::AXI_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Register side
    output logic wr_en,
    output am_seg_pkg::reg_sel_e wr_sel,
    output logic [am_seg_pkg::REG_W-1:0] wr_data,
    output am_seg_pkg::reg_sel_e rd_sel,
    input wire logic [am_seg_pkg::REG_W-1:0] rd_data
);
    import am_seg_pkg::*;

    logic aw_held_reg;
    logic w_held_reg;
    logic ar_held_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [ADDR_W-1:0] ar_addr_reg;
    logic [REG_W-1:0] w_data_reg;
    logic w_lane0_reg;
    logic wr_fire;

    // ==========================================================
    // Write path: address and data taken in either order
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_sel = reg_decode(aw_addr_reg);
    assign wr_en = wr_fire && w_lane0_reg && (wr_sel != SEL_NONE);
    assign wr_data = w_data_reg;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else begin
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            s_axi_awready <= !aw_held_reg && !s_axi_bvalid;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= '0;
            w_lane0_reg <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[REG_W-1:0];
            w_lane0_reg <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end else begin
            if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
            s_axi_wready <= !w_held_reg && !s_axi_bvalid;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Read path: data registered one cycle after address
    assign rd_sel = reg_decode(ar_addr_reg);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ar_held_reg <= 1'b0;
            ar_addr_reg <= '0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            ar_held_reg <= 1'b1;
            ar_addr_reg <= s_axi_araddr;
            s_axi_arready <= 1'b0;
        end else if (ar_held_reg) begin
            ar_held_reg <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {{(AXI_DATA_W-REG_W){1'b0}}, rd_data};
            s_axi_rresp <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else begin
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_rvalid;
        end
    end

endmodule // axil_reg_port

// File: hdl/am_driver_segment_control.sv
`timescale 1ns/10ps
// Notes on behaviour
// RL1 - Modulated mask comes from calibration result when source bit is 0, else manual.
// RL2 - Depth control bits 6..1 hold six-bit target level, bit 6 most significant.
// RL3 - Calibration result is a read-only byte; set bit disables segment when modulated.
// RL4 - A failed calibration loads all ones into the result register.
// RL5 - With source bit 1, manual mask bits disable their segments while modulated.
// RL6 - Mask bits 7..0 map to segments weighted 2 up to 256 ohms.
// RL7 - Normal mask bits disable their segments during normal transmission.
// RL8 - Normal mask all ones puts the antenna drivers into high impedance.
// RL9 - Power-up and set-default clear control, manual and normal mask registers.
// RL10 - Power-up and set-default clear the calibration result register; a same-cycle cal_done loads the new result instead.
// RL11 - Segment outputs follow modulated mask while modulating, otherwise normal mask.
module am_driver_segment_control (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // AXI4-Lite write
    input wire logic [am_seg_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [am_seg_pkg::AXI_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [am_seg_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [am_seg_pkg::AXI_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Command and calibration engine
    input wire logic set_default_cmd,
    input wire logic cal_done,
    input wire logic cal_fail,
    input wire logic [am_seg_pkg::REG_W-1:0] cal_result,
    output logic [am_seg_pkg::TARGET_W-1:0] target_level,
    // Transmitter
    input wire logic modulation_active,
    output logic [am_seg_pkg::REG_W-1:0] segment_disable,
    output logic drivers_tristate
);
    import am_seg_pkg::*;

    logic [REG_W-1:0] depth_control_reg;
    logic [REG_W-1:0] depth_result_reg;
    logic [REG_W-1:0] modulated_mask_reg;
    logic [REG_W-1:0] normal_mask_reg;
    logic [REG_W-1:0] depth_result_next;
    logic [REG_W-1:0] selected_mod_mask;
    logic [REG_W-1:0] segment_disable_next;
    logic modulated_source_select;
    logic wr_en;
    reg_sel_e wr_sel;
    logic [REG_W-1:0] wr_data;
    reg_sel_e rd_sel;
    logic [REG_W-1:0] rd_data;

    // ==========================================================
    // Bus slave
    axil_reg_port u_port (
        .core_clk(core_clk),
        .rstn(rstn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_sel(wr_sel),
        .wr_data(wr_data),
        .rd_sel(rd_sel),
        .rd_data(rd_data)
    );

    // ==========================================================
    // Software registers; set-default outranks a same-cycle write
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            depth_control_reg <= REG_RESET; // RL9
        end else if (set_default_cmd) begin
            depth_control_reg <= REG_RESET; // RL9
        end else if (wr_en && wr_sel == SEL_DEPTH_CONTROL) begin
            depth_control_reg <= wr_data;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            modulated_mask_reg <= REG_RESET; // RL9
        end else if (set_default_cmd) begin
            modulated_mask_reg <= REG_RESET; // RL9
        end else if (wr_en && wr_sel == SEL_MODULATED_MASK) begin
            modulated_mask_reg <= wr_data;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            normal_mask_reg <= REG_RESET; // RL9
        end else if (set_default_cmd) begin
            normal_mask_reg <= REG_RESET; // RL9
        end else if (wr_en && wr_sel == SEL_NORMAL_MASK) begin
            normal_mask_reg <= wr_data; // RL7
        end
    end

    // ==========================================================
    // Calibration result; a finishing calibration wins over set-default
    always_comb begin
        depth_result_next = depth_result_reg;
        if (set_default_cmd) begin
            depth_result_next = REG_RESET; // RL10
        end
        if (cal_done) begin
            if (cal_fail) begin
                depth_result_next = CAL_FAIL_VALUE; // RL4
            end else begin
                depth_result_next = cal_result; // RL3
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            depth_result_reg <= REG_RESET; // RL10
        end else begin
            depth_result_reg <= depth_result_next;
        end
    end

    // ==========================================================
    // Target level for the calibration engine
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            target_level <= TARGET_RESET;
        end else begin
            target_level <= depth_control_reg[TARGET_LEVEL_MSB:TARGET_LEVEL_LSB]; // RL2
        end
    end

    // ==========================================================
    // Segment selection; bit 7 is the 2 ohm segment, bit 0 the 256 ohm one
    assign modulated_source_select = depth_control_reg[SOURCE_SELECT_BIT];

    always_comb begin
        if (modulated_source_select == SOURCE_MANUAL) begin
            selected_mod_mask = modulated_mask_reg; // RL5
        end else begin
            selected_mod_mask = depth_result_reg; // RL1
        end
    end

    genvar seg;
    generate
        for (seg = 0; seg < REG_W; seg++) begin : g_segment
            assign segment_disable_next[seg] = modulation_active ?
                selected_mod_mask[seg] : normal_mask_reg[seg]; // RL11
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            segment_disable <= REG_RESET;
        end else begin
            segment_disable <= segment_disable_next; // RL6
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            drivers_tristate <= 1'b0;
        end else begin
            drivers_tristate <= (normal_mask_reg == TRISTATE_MASK); // RL8
        end
    end

    // ==========================================================
    // Read mux
    always_comb begin
        case (rd_sel)
            SEL_DEPTH_CONTROL: rd_data = depth_control_reg;
            SEL_DEPTH_RESULT: rd_data = depth_result_reg;
            SEL_MODULATED_MASK: rd_data = modulated_mask_reg;
            SEL_NORMAL_MASK: rd_data = normal_mask_reg;
            default: rd_data = REG_RESET;
        endcase
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    a_manual_mask_used: assert property ( // RL5
        modulation_active && modulated_source_select == SOURCE_MANUAL
        |=> segment_disable == $past(modulated_mask_reg))
        else $error("manual modulated mask not on segment outputs");

    a_cal_mask_used: assert property ( // RL1
        modulation_active && modulated_source_select == SOURCE_CALIBRATED
        |=> segment_disable == $past(depth_result_reg))
        else $error("calibrated mask not on segment outputs");

    a_normal_mask_used: assert property ( // RL7
        !modulation_active |=> segment_disable == $past(normal_mask_reg))
        else $error("normal mask not on segment outputs");

    a_segment_switch: assert property ( // RL11
        $rose(modulation_active) ##1 modulation_active
        |-> segment_disable == $past(selected_mod_mask))
        else $error("segments did not follow modulation start");

    a_cal_fail_load: assert property ( // RL4
        cal_done && cal_fail |=> depth_result_reg == CAL_FAIL_VALUE)
        else $error("failed calibration did not load all ones");

    a_cal_result_load: assert property ( // RL3
        cal_done && !cal_fail |=> depth_result_reg == $past(cal_result))
        else $error("calibration result not stored");

    a_result_holds: assert property ( // RL3
        !cal_done && !set_default_cmd |=> $stable(depth_result_reg))
        else $error("result register changed without cause");

    a_default_clear: assert property ( // RL9
        set_default_cmd |=> depth_control_reg == REG_RESET
            && modulated_mask_reg == REG_RESET && normal_mask_reg == REG_RESET)
        else $error("set-default left a register non-zero");

    a_default_result: assert property ( // RL10
        set_default_cmd && !cal_done |=> depth_result_reg == REG_RESET)
        else $error("set-default did not clear result");

    a_target_field: assert property ( // RL2
        wr_en && wr_sel == SEL_DEPTH_CONTROL && !set_default_cmd
        |=> ##1 target_level == $past(wr_data[TARGET_LEVEL_MSB:TARGET_LEVEL_LSB], 2))
        else $error("target level does not follow bits 6 to 1");

    a_tristate_all: assert property ( // RL8
        wr_en && wr_sel == SEL_NORMAL_MASK && wr_data == TRISTATE_MASK
        && !set_default_cmd |=> ##1 drivers_tristate)
        else $error("all-ones normal mask did not tristate drivers");

    a_tristate_off: assert property ( // RL8
        normal_mask_reg != TRISTATE_MASK |=> !drivers_tristate)
        else $error("drivers tristated without all-ones mask");

    a_bit_order: assert property ( // RL6
        !modulation_active && normal_mask_reg[REG_W-1]
        |=> segment_disable[REG_W-1])
        else $error("2 ohm segment bit misplaced");

    a_ctrl_write: assert property ( // RL2
        wr_en && wr_sel == SEL_DEPTH_CONTROL && !set_default_cmd
        |=> depth_control_reg == $past(wr_data))
        else $error("depth control write not stored");

    a_mask_write: assert property ( // RL5
        wr_en && wr_sel == SEL_MODULATED_MASK && !set_default_cmd
        |=> modulated_mask_reg == $past(wr_data))
        else $error("modulated mask write not stored");

    a_normal_write: assert property ( // RL7
        wr_en && wr_sel == SEL_NORMAL_MASK && !set_default_cmd
        |=> normal_mask_reg == $past(wr_data))
        else $error("normal mask write not stored");

    a_tristate_on: assert property ( // RL8
        normal_mask_reg == TRISTATE_MASK |=> drivers_tristate)
        else $error("drivers not tristated while normal mask is all ones");

    a_bit_lsb: assert property ( // RL6
        !modulation_active && normal_mask_reg[0] |=> segment_disable[0])
        else $error("256 ohm segment bit misplaced");

    a_result_readback: assert property ( // RL3
        $rose(s_axi_rvalid) && rd_sel == SEL_DEPTH_RESULT
        |-> s_axi_rdata[REG_W-1:0] == $past(depth_result_reg))
        else $error("result register read back wrong");

    a_result_no_write: assert property ( // RL3
        wr_en && wr_sel == SEL_DEPTH_RESULT && !cal_done && !set_default_cmd
        |=> $stable(depth_result_reg))
        else $error("bus write reached the result register");

endmodule // am_driver_segment_control

// File: tb/am_driver_segment_control_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) \
    begin \
        comparisons++; \
        if ((g) !== (e)) begin \
            num_errors++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end

module am_driver_segment_control_tb;
    import am_seg_pkg::*;

    // ==========================================================
    // Signals
    logic core_clk;
    logic rstn;
    logic [ADDR_W-1:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [AXI_DATA_W-1:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [ADDR_W-1:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [AXI_DATA_W-1:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    logic set_default_cmd;
    logic cal_done;
    logic cal_fail;
    logic [REG_W-1:0] cal_result;
    logic [TARGET_W-1:0] target_level;
    logic modulation_active;
    logic [REG_W-1:0] segment_disable;
    logic drivers_tristate;
    int num_errors = 0;
    int comparisons = 0;
    logic [1:0] b_q[$];
    logic [33:0] r_q[$];
    logic [1:0] exp_b;
    logic [33:0] exp_r;
    logic [REG_W-1:0] m_ctrl;
    logic [REG_W-1:0] m_mm;
    logic [REG_W-1:0] m_nm;
    logic [REG_W-1:0] m_res;

    am_driver_segment_control u_am_driver_segment_control (
        .core_clk(core_clk), .rstn(rstn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .set_default_cmd(set_default_cmd), .cal_done(cal_done), .cal_fail(cal_fail),
        .cal_result(cal_result), .target_level(target_level),
        .modulation_active(modulation_active), .segment_disable(segment_disable),
        .drivers_tristate(drivers_tristate)
    );

    // ==========================================================
    // Clock and watchdog
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        $display("Watchdog expired");
        test_done();
    end

    // ==========================================================
    // Response monitor: oldest note against each answer
    always @(posedge core_clk) begin
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
            exp_b = (b_q.size() != 0) ? b_q.pop_front() : 2'hX;
            `CHK(s_axi_bresp, exp_b)
        end
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            exp_r = (r_q.size() != 0) ? r_q.pop_front() : 34'hX;
            `CHK({s_axi_rresp, s_axi_rdata}, exp_r)
        end
    end

    // ==========================================================
    // Bus tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int n;
        logic b_ok;
        b_q.push_back(er);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'($urandom()), d};
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        b_ok = 1'b0;
        while (!b_ok && n < 200) begin
            @(posedge core_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                b_ok = 1'b1;
                s_axi_bready <= 1'b0;
            end
        end
        if (!b_ok) num_errors++;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        logic r_ok;
        r_q.push_back({er, 24'h000000, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        r_ok = 1'b0;
        while (!r_ok && n < 200) begin
            @(posedge core_clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                r_ok = 1'b1;
                s_axi_rready <= 1'b0;
            end
        end
        if (!r_ok) num_errors++;
        @(posedge core_clk);
    endtask

    task automatic rd_all();
        rd(ADDR_DEPTH_CONTROL, m_ctrl, RESP_OKAY);
        rd(ADDR_DEPTH_RESULT, m_res, RESP_OKAY);
        rd(ADDR_MODULATED_MASK, m_mm, RESP_OKAY);
        rd(ADDR_NORMAL_MASK, m_nm, RESP_OKAY);
    endtask

    task automatic chk_out();
        repeat (3) @(posedge core_clk);
        `CHK(segment_disable, modulation_active ? (m_ctrl[7] ? m_mm : m_res) : m_nm)
        `CHK(target_level, m_ctrl[6:1])
        `CHK(drivers_tristate, (m_nm == 8'hFF))
    endtask

    task automatic pulse_cal(input logic fail, input logic [7:0] v);
        cal_done <= 1'b1;
        cal_fail <= fail;
        cal_result <= v;
        @(posedge core_clk);
        cal_done <= 1'b0;
        cal_fail <= 1'b0;
        cal_result <= 8'($urandom());
        m_res = fail ? 8'hFF : v;
        @(posedge core_clk);
    endtask

    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        {set_default_cmd, cal_done, cal_fail, cal_result, modulation_active} = '0;
        {m_ctrl, m_mm, m_nm, m_res} = '0;
        void'($urandom(76));
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);

        rd_all();
        rd(8'hA0, 8'h00, RESP_SLVERR);
        chk_out();
        $display("Test reset values done");

        m_ctrl = 8'($urandom());
        m_mm = 8'($urandom());
        m_nm = 8'($urandom()) & 8'h7F;
        wr(ADDR_DEPTH_CONTROL, m_ctrl, 4'hF, RESP_OKAY);
        wr(ADDR_MODULATED_MASK, m_mm, 4'hF, RESP_OKAY);
        wr(ADDR_NORMAL_MASK, m_nm, 4'hF, RESP_OKAY);
        wr(ADDR_DEPTH_RESULT, 8'h5A, 4'hF, RESP_OKAY);
        wr(ADDR_NORMAL_MASK, 8'hFF, 4'hE, RESP_OKAY);
        wr(8'h8C, 8'h33, 4'hF, RESP_SLVERR);
        rd_all();
        chk_out();
        $display("Test register access done");

        pulse_cal(1'b0, 8'($urandom()));
        rd(ADDR_DEPTH_RESULT, m_res, RESP_OKAY);
        pulse_cal(1'b1, 8'h12);
        rd(ADDR_DEPTH_RESULT, CAL_FAIL_VALUE, RESP_OKAY);
        pulse_cal(1'b0, 8'hA5);
        $display("Test calibration done");

        for (int k = 0; k < 4; k++) begin
            m_ctrl = {k[0], 7'($urandom())};
            wr(ADDR_DEPTH_CONTROL, m_ctrl, 4'hF, RESP_OKAY);
            modulation_active <= k[1];
            chk_out();
        end
        modulation_active <= 1'b0;
        $display("Test source select done");

        for (int i = 0; i < 8; i++) begin
            m_nm = 8'h01 << i;
            wr(ADDR_NORMAL_MASK, m_nm, 4'hF, RESP_OKAY);
            chk_out();
        end
        m_nm = 8'hC0;
        wr(ADDR_NORMAL_MASK, m_nm, 4'hF, RESP_OKAY);
        chk_out();
        m_nm = 8'hFF;
        wr(ADDR_NORMAL_MASK, m_nm, 4'hF, RESP_OKAY);
        modulation_active <= 1'b1;
        chk_out();
        m_nm = 8'hFE;
        wr(ADDR_NORMAL_MASK, m_nm, 4'hF, RESP_OKAY);
        chk_out();
        $display("Test segment weights done");

        set_default_cmd <= 1'b1;
        @(posedge core_clk);
        set_default_cmd <= 1'b0;
        {m_ctrl, m_mm, m_nm, m_res} = '0;
        @(posedge core_clk);
        rd_all();
        chk_out();
        // Calibration finishing with set-default: the new result is loaded
        set_default_cmd <= 1'b1;
        cal_done <= 1'b1;
        cal_result <= 8'h3C;
        @(posedge core_clk);
        set_default_cmd <= 1'b0;
        cal_done <= 1'b0;
        m_res = 8'h3C;
        @(posedge core_clk);
        rd(ADDR_DEPTH_RESULT, m_res, RESP_OKAY);
        $display("Test set default done");
        test_done();
    end
endmodule // am_driver_segment_control_tb
